// ### verilog/lam_pkg.sv
// Shared constants and types for the line alarm monitor
package lam_pkg;
  // Detection thresholds, in recovered bit periods
  localparam int LAM_AIS_RUN = 2048;
  localparam int LAM_WIN_LEN = 512;
  localparam int LAM_LOSS_MIN = 120;
  // Register byte offsets
  localparam logic [7:0] LAM_OFS_STATUS = 8'h00;
  localparam logic [7:0] LAM_OFS_CLEAR = 8'h04;
  localparam logic [7:0] LAM_OFS_ENABLE = 8'h08;
  localparam logic [7:0] LAM_OFS_STATE = 8'h0C;
  // Event bit positions in status, clear and enable
  localparam int LAM_EV_AIS = 0;
  localparam int LAM_EV_LOSS = 1;
  localparam int LAM_EV_TAKE = 2;
  localparam int LAM_EV_N = 3;
  // State register bit positions
  localparam int LAM_ST_AIS = 0;
  localparam int LAM_ST_LOSS = 1;
  localparam int LAM_ST_SERVICE = 2;
  localparam int LAM_ST_ALARM = 3;
  // Reset values
  localparam logic [2:0] LAM_STATUS_RST = 3'h0;
  localparam logic [2:0] LAM_ENABLE_RST = 3'h0;
  // Module role in a protected pair
  typedef enum logic {LAM_MAIN, LAM_STANDBY} lam_role_e;
  // Synchronised pin set
  typedef struct packed {
    logic mark_pos;
    logic mark_neg;
    logic button;
    logic ext_req_n;
    logic inhibit;
    logic ais_dis;
    logic release_n;
  } lam_pins_s;
  // Synchroniser reset value: active-low pins idle high, the rest idle low
  localparam logic [6:0] LAM_PIN_RST = 7'h09;
endpackage

// ### verilog/lam_window.sv
// Windowed ones counter that flags data loss
`timescale 1ns/10ps
`default_nettype none
module lam_window #(
  parameter int WIN_LEN = lam_pkg::LAM_WIN_LEN,
  parameter int LOSS_MIN = lam_pkg::LAM_LOSS_MIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic one,
  output var logic loss
);
  localparam int CW = $clog2(WIN_LEN);
  localparam int OW = $clog2(WIN_LEN + 1);

  logic [CW-1:0] cyc_r, cyc_nxt;
  logic [OW-1:0] ones_r, ones_nxt, total;
  logic loss_r, loss_nxt, win_end;

  // Fixed, non-overlapping windows; verdict only at the last period
  always_comb begin
    win_end = (cyc_r == CW'(WIN_LEN - 1));
    total = ones_r + OW'(one);
    cyc_nxt = win_end ? '0 : cyc_r + CW'(1);
    ones_nxt = win_end ? '0 : total;
    loss_nxt = win_end ? (total < OW'(LOSS_MIN)) : loss_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= '0;
      ones_r <= '0;
      loss_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      ones_r <= ones_nxt;
      loss_r <= loss_nxt;
    end
  end

  assign loss = loss_r;

  a_loss_verdict: assert property (@(posedge pclk) disable iff (!presetn)
    win_end |=> loss_r == ($past(total) < OW'(LOSS_MIN)))
    else $error("data loss verdict wrong at window end");
  a_loss_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !win_end |=> $stable(loss_r))
    else $error("data loss changed inside a window");
  a_window_restart: assert property (@(posedge pclk) disable iff (!presetn)
    win_end |=> cyc_r == '0 && ones_r == '0)
    else $error("window did not restart");
endmodule
`default_nettype wire

// ### verilog/lam_monitor.sv
// Line alarm monitor: alarm detection, changeover control, APB registers
// Overview of operation
// - Flag alarm indication after 2048 or more consecutive ones.
// - Flag data loss when under 120 ones occur in 512 periods.
// - General alarm on data loss, or on alarm indication unless link fitted.
// - Grounded external request acts like the front-panel button unless inhibit is set.
// - Separate indicators for loss, alarm indication, in service, standby.
// - Button may make this module main only with no alarm present.
// - External request ignored while changeover inhibit switch is set.
// - A mark of either polarity counts as one data one.
`timescale 1ns/10ps
`default_nettype none
module lam_monitor #(
  parameter int AIS_RUN = lam_pkg::LAM_AIS_RUN,
  parameter int WIN_LEN = lam_pkg::LAM_WIN_LEN,
  parameter int LOSS_MIN = lam_pkg::LAM_LOSS_MIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mark_pos,
  input wire logic mark_neg,
  input wire logic change_button,
  input wire logic ext_request_n,
  input wire logic inhibit_switch,
  input wire logic alarm_indication_disable_link,
  input wire logic standby_release_n,
  output logic general_alarm_n,
  output logic led_data_loss,
  output logic led_ais,
  output logic led_in_service,
  output logic led_standby,
  output logic irq
);
  localparam int RW = $clog2(AIS_RUN + 1);
  localparam int NP = $bits(lam_pkg::lam_pins_s);
  localparam int NE = lam_pkg::LAM_EV_N;

  // Two-stage synchronisers; first stage read only by the second
  // Reset to pin idle levels so no false release or request follows reset
  logic [NP-1:0] raw, s1_r, s2_r;
  lam_pkg::lam_pins_s pin;
  assign raw = {mark_pos, mark_neg, change_button, ext_request_n, inhibit_switch,
                alarm_indication_disable_link, standby_release_n};
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi] <= lam_pkg::LAM_PIN_RST[gi];
          s2_r[gi] <= lam_pkg::LAM_PIN_RST[gi];
        end else begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate
  assign pin = lam_pkg::lam_pins_s'(s2_r);

  // Either mark polarity is a one; HDB3 alternates pulse sign
  logic one;
  assign one = pin.mark_pos | pin.mark_neg;

  // Consecutive-ones run, saturating so a long alarm does not wrap
  logic [RW-1:0] run_r, run_nxt;
  logic ais;
  always_comb begin
    if (!one) begin
      run_nxt = '0;
    end else if (run_r == RW'(AIS_RUN)) begin
      run_nxt = run_r;
    end else begin
      run_nxt = run_r + RW'(1);
    end
  end
  assign ais = (run_r == RW'(AIS_RUN));

  // Data loss over fixed windows
  logic loss;
  lam_window #(.WIN_LEN(WIN_LEN), .LOSS_MIN(LOSS_MIN)) u_window (
    .pclk(pclk),
    .presetn(presetn),
    .one(one),
    .loss(loss)
  );

  // Changeover request: button or grounded external input, edge triggered
  logic req_lvl, req_edge, req_prev_r, gen;
  assign req_lvl = pin.button | (~pin.ext_req_n & ~pin.inhibit);
  assign req_edge = req_lvl & ~req_prev_r;
  assign gen = loss | (ais & ~pin.ais_dis);

  // Role: powers up as main; partner status drops us to standby
  lam_pkg::lam_role_e role_r, role_nxt;
  always_comb begin
    role_nxt = role_r;
    case (role_r)
      lam_pkg::LAM_MAIN: begin
        if (!pin.release_n) begin
          role_nxt = lam_pkg::LAM_STANDBY;
        end
      end
      lam_pkg::LAM_STANDBY: begin
        // Refusing on any alarm keeps a faulty path from seizing traffic
        if (req_edge && !ais && !loss) begin
          role_nxt = lam_pkg::LAM_MAIN;
        end
      end
      default: role_nxt = lam_pkg::LAM_MAIN;
    endcase
  end

  // Events, sticky status, enable; a set beats a same-cycle clear
  logic acc, wr, hit;
  logic [NE-1:0] ev, clr, status_r, status_nxt, enable_r, enable_nxt;
  logic ais_prev_r, loss_prev_r;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign ev = {role_r == lam_pkg::LAM_STANDBY && role_nxt == lam_pkg::LAM_MAIN,
               loss & ~loss_prev_r, ais & ~ais_prev_r};
  assign clr = (wr && paddr == lam_pkg::LAM_OFS_CLEAR) ? pwdata[NE-1:0] : '0;
  always_comb begin
    status_nxt = (status_r & ~clr) | ev;
    enable_nxt = (wr && paddr == lam_pkg::LAM_OFS_ENABLE) ? pwdata[NE-1:0] : enable_r;
  end

  // Registered outputs so pins never glitch on comparator settling
  logic alarm_n_nxt, loss_led_nxt, ais_led_nxt, serv_nxt;
  always_comb begin
    alarm_n_nxt = ~gen;
    loss_led_nxt = loss;
    ais_led_nxt = ais;
    serv_nxt = (role_nxt == lam_pkg::LAM_MAIN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= '0;
      req_prev_r <= 1'b0;
      role_r <= lam_pkg::LAM_MAIN;
      status_r <= lam_pkg::LAM_STATUS_RST;
      enable_r <= lam_pkg::LAM_ENABLE_RST;
      ais_prev_r <= 1'b0;
      loss_prev_r <= 1'b0;
      general_alarm_n <= 1'b1;
      led_data_loss <= 1'b0;
      led_ais <= 1'b0;
      led_in_service <= 1'b1;
      led_standby <= 1'b0;
    end else begin
      run_r <= run_nxt;
      req_prev_r <= req_lvl;
      role_r <= role_nxt;
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      ais_prev_r <= ais;
      loss_prev_r <= loss;
      general_alarm_n <= alarm_n_nxt;
      led_data_loss <= loss_led_nxt;
      led_ais <= ais_led_nxt;
      led_in_service <= serv_nxt;
      led_standby <= ~serv_nxt;
    end
  end

  assign irq = |(status_r & enable_r);

  // Zero-wait APB slave; unmapped offsets answer with an error
  always_comb begin
    prdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      lam_pkg::LAM_OFS_STATUS: prdata[NE-1:0] = status_r;
      lam_pkg::LAM_OFS_CLEAR: prdata = 32'h0000_0000;
      lam_pkg::LAM_OFS_ENABLE: prdata[NE-1:0] = enable_r;
      lam_pkg::LAM_OFS_STATE: begin
        prdata[lam_pkg::LAM_ST_AIS] = ais;
        prdata[lam_pkg::LAM_ST_LOSS] = loss;
        prdata[lam_pkg::LAM_ST_SERVICE] = (role_r == lam_pkg::LAM_MAIN);
        prdata[lam_pkg::LAM_ST_ALARM] = gen;
      end
      default: hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ais_clear: assert property (!one |=> !ais)
    else $error("alarm indication survived a zero");
  a_ais_count: assert property (one && run_r == RW'(AIS_RUN - 1) |=> ais)
    else $error("alarm indication not raised at run threshold");
  a_neg_mark_one: assert property (pin.mark_neg && !pin.mark_pos && run_r == '0
    |=> run_r == RW'(1))
    else $error("negative mark not counted as a one");
  a_alarm_loss: assert property (loss |=> !general_alarm_n)
    else $error("general alarm missing on data loss");
  a_alarm_masked: assert property (!loss && pin.ais_dis |=> general_alarm_n)
    else $error("general alarm raised with link fitted and no loss");
  a_led_track: assert property (##1 led_ais == $past(ais) && led_data_loss == $past(loss)
    && led_in_service != led_standby)
    else $error("indicator mismatch");
  a_takeover_block: assert property (role_r == lam_pkg::LAM_STANDBY && (ais || loss)
    |=> role_r == lam_pkg::LAM_STANDBY)
    else $error("took over while alarm present");
  a_inhibit_ext: assert property (role_r == lam_pkg::LAM_STANDBY && pin.inhibit
    && !pin.button |=> role_r == lam_pkg::LAM_STANDBY)
    else $error("external request honoured while inhibited");
  a_ext_request: assert property (role_r == lam_pkg::LAM_STANDBY && !pin.ext_req_n
    && !pin.inhibit && !req_prev_r && !ais && !loss |=> role_r == lam_pkg::LAM_MAIN)
    else $error("external request not acted on");
  c_ais: cover property ($rose(ais));
  c_loss: cover property ($rose(loss));
  c_takeover: cover property (ev[lam_pkg::LAM_EV_TAKE]);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### sim/lam_line_model.sv
// Line front end model: alternate-polarity marks from a data bit stream
`timescale 1ns/10ps
`default_nettype none
module lam_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_bit,
  output logic mark_pos,
  output logic mark_neg
);
  logic pol_r;
  // Ones alternate polarity, spaces leave both lines low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= 1'b0;
      mark_pos <= 1'b0;
      mark_neg <= 1'b0;
    end else begin
      mark_pos <= data_bit & ~pol_r;
      mark_neg <= data_bit & pol_r;
      pol_r <= pol_r ^ data_bit;
    end
  end
endmodule
`default_nettype wire

// ### sim/lam_testbench.sv
// Self-checking bench for the line alarm monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int AR = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, data_bit = 0, seen = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ok, mark_pos, mark_neg, ga_n, l_loss, l_ais, l_srv, l_sby, irq;
  logic button = 0, ext_n = 1, inhibit = 0, link = 0, rel_n = 1;
  int errors = 0, tests_run = 0, seed = 32'h71f73050, run_len = 0, period = 1, ph = 0, r;
  lam_line_model line (.pclk(pclk), .presetn(presetn), .data_bit(data_bit),
    .mark_pos(mark_pos), .mark_neg(mark_neg));
  lam_monitor #(.AIS_RUN(AR), .WIN_LEN(16), .LOSS_MIN(4)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mark_pos(mark_pos),
    .mark_neg(mark_neg), .change_button(button), .ext_request_n(ext_n),
    .inhibit_switch(inhibit), .alarm_indication_disable_link(link),
    .standby_release_n(rel_n), .general_alarm_n(ga_n), .led_data_loss(l_loss),
    .led_ais(l_ais), .led_in_service(l_srv), .led_standby(l_sby), .irq(irq));
  always #10 pclk = ~pclk;
  // Data pattern: run_len ones at the start of each period
  always @(posedge pclk) begin
    data_bit <= ph < run_len;
    ph <= (ph + 1 >= period) ? 0 : ph + 1;
    if (l_ais === 1'b1) seen <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pat(input int l, input int p, input int n);
    run_len <= l;
    period <= p;
    tick(n);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, waits for pready, idle edge after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      ok = pready;
      rd = prdata;
      er = pslverr;
    end while (ok !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic req(input logic ext, input logic [1:0] e);
    if (ext) ext_n <= 1'b0;
    else button <= 1'b1;
    tick(8);
    ext_n <= 1'b1;
    button <= 1'b0;
    tick(4);
    chk("role", e, {l_srv, l_sby});
  endtask
  task automatic stby;
    rel_n <= 1'b0;
    tick(6);
    rel_n <= 1'b1;
    tick(4);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(1);
    chk("leds", 32'h4, {ga_n ^ 1'b1, l_loss, l_ais, l_srv, l_sby, irq});
    apb(0, lam_pkg::LAM_OFS_STATUS, 0);
    chk("status", 32'h0, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    r = $random(seed);
    apb(1, lam_pkg::LAM_OFS_ENABLE, r);
    apb(0, lam_pkg::LAM_OFS_ENABLE, 0);
    chk("enable", r & 32'h7, rd);
    pat(1, 4, 64);
    chk("loss", 32'h0, l_loss);
    apb(1, lam_pkg::LAM_OFS_CLEAR, 32'h7);
    apb(1, lam_pkg::LAM_OFS_ENABLE, 32'h3);
    chk("irq", 32'h0, irq);
    pat(1, 6, 64);
    link <= 1'b1;
    tick(4);
    chk("loss", 32'h0, {l_loss, ga_n, irq} ^ 3'h5);
    link <= 1'b0;
    pat(1, 1, 64);
    apb(0, lam_pkg::LAM_OFS_STATE, 0);
    chk("state", 32'hD, rd);
    link <= 1'b1;
    tick(4);
    apb(0, lam_pkg::LAM_OFS_STATUS, 0);
    chk("status", 32'h3, rd);
    chk("alarm_n", 32'h3, {ga_n, l_ais});
    apb(1, lam_pkg::LAM_OFS_CLEAR, 32'h3);
    chk("irq", 32'h0, irq);
    pat(0, 1, 12);
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? AR - 1 : (i == 1) ? AR : 1 + $unsigned($random(seed)) % 14;
      seen <= 1'b0;
      pat(r, r + 12, 2 * (r + 12));
      chk("ais_run", r >= AR, seen);
      pat(0, 1, 12);
    end
    pat(1, 2, 64);
    stby();
    chk("standby", 32'h1, {l_srv, l_sby});
    pat(0, 1, 48);
    req(0, 2'b01);
    pat(1, 2, 48);
    req(0, 2'b10);
    apb(0, lam_pkg::LAM_OFS_STATUS, 0);
    chk("took", 32'h4, rd & 32'h4);
    apb(1, lam_pkg::LAM_OFS_CLEAR, 32'h7);
    apb(1, lam_pkg::LAM_OFS_ENABLE, 32'h4);
    stby();
    inhibit <= 1'b1;
    req(1, 2'b01);
    inhibit <= 1'b0;
    req(1, 2'b10);
    chk("irq", 32'h1, irq);
    print_verdict();
  end
endmodule
`default_nettype wire
